/* File: logic/eestat_pkg.sv */
// Constants, register map and counter layout for the Ethernet error statistics block.
package eestat_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int             ADDR_W          = 8;
   localparam logic [7:0]     CONFIG_OFFSET   = 8'h00;
   localparam logic [7:0]     COUNTER_BASE    = 8'h08;
   localparam int             NUM_COUNTERS    = 11;
   localparam logic [31:0]    CONFIG_RESET    = 32'h0000_0000;
   localparam logic [31:0]    CONFIG_MASK     = 32'h0001_0103;
   localparam logic [15:0]    COUNTER_RESET   = 16'h0000;

   // Counter index; byte address is COUNTER_BASE plus four times the index.
   typedef enum logic [3:0] {
      CNT_EXCESS_COLLISIONS  = 4'h0,
      CNT_TX_UNDERRUNS       = 4'h1,
      CNT_CARRIER_SENSE      = 4'h2,
      CNT_RX_RESOURCE        = 4'h3,
      CNT_RX_OVERRUNS        = 4'h4,
      CNT_RX_SYMBOL          = 4'h5,
      CNT_EXCESS_LENGTH      = 4'h6,
      CNT_RX_JABBERS         = 4'h7,
      CNT_UNDERSIZE          = 4'h8,
      CNT_SQE_TEST           = 4'h9,
      CNT_LENGTH_MISMATCH    = 4'ha
   } eestat_counter_type;

   // ---------------------------------------------------------------
   // Configuration fields
   // ---------------------------------------------------------------
   localparam int             CFG_SPEED_BIT       = 0;
   localparam int             CFG_FULL_DUPLEX_BIT = 1;
   localparam int             CFG_BIG_FRAMES_BIT  = 8;
   localparam int             CFG_LEN_CHECK_BIT   = 16;

   // ---------------------------------------------------------------
   // Frame limits
   // ---------------------------------------------------------------
   localparam logic [13:0]    MIN_FRAME_BYTES     = 14'd64;
   localparam logic [13:0]    MAX_FRAME_BYTES     = 14'd1518;
   localparam logic [13:0]    MAX_FRAME_BIG_BYTES = 14'd1536;
   localparam logic [13:0]    HDR_FCS_BYTES       = 14'd18;
   localparam logic [15:0]    TYPE_ID_MIN         = 16'h0600;
   localparam logic [4:0]     COLLISION_LIMIT     = 5'd16;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int             CLK_PERIOD_NS       = 10;
   localparam int             BIT_NS_FAST         = 10;
   localparam int             BIT_NS_SLOW         = 100;
   localparam int             BIT_CYC_FAST        = (BIT_NS_FAST / CLK_PERIOD_NS < 1) ? 1 : BIT_NS_FAST / CLK_PERIOD_NS;
   localparam int             BIT_CYC_SLOW        = (BIT_NS_SLOW / CLK_PERIOD_NS < 1) ? 1 : BIT_NS_SLOW / CLK_PERIOD_NS;
   localparam logic [6:0]     SQE_WINDOW_BITS     = 7'd96;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0]     RESP_OKAY           = 2'b00;
   localparam logic [1:0]     RESP_SLVERR         = 2'b10;

   // Width of each counter in bits.
   function automatic int counter_width(input int idx);
      return (idx == int'(CNT_RX_RESOURCE)) ? 16 : 8;
   endfunction : counter_width

endpackage : eestat_pkg

/* File: logic/eestat_counters.sv */
// Error statistics counter bank with its AXI4-Lite register slave.
`timescale 1ns/1ns
module eestat_counters (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [eestat_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [eestat_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          tx_en,
   input  wire logic                          tx_frame_done,
   input  wire logic [4:0]                    tx_collision_total,
   input  wire logic                          tx_underrun,
   input  wire logic                          phy_crs,
   input  wire logic                          collision_input,
   input  wire logic                          phy_rx_dv,
   input  wire logic                          phy_rx_er,
   input  wire logic                          rx_frame_done,
   input  wire logic [13:0]                   rx_frame_length,
   input  wire logic [15:0]                   rx_length_field,
   input  wire logic                          rx_crc_error,
   input  wire logic                          rx_odd_bits,
   input  wire logic                          rx_address_match,
   input  wire logic                          rx_no_buffer,
   input  wire logic                          rx_dma_overrun,
   output logic                               rx_symbol_fcs_event,
   output logic                               rx_symbol_align_event
);
   import eestat_pkg::*;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------

   // Next counter value: a software load and a hit in the same cycle both count.
   function automatic logic [15:0] step_counter(input logic [15:0] cur,
                                                input logic        load,
                                                input logic [15:0] loadval,
                                                input logic        hit,
                                                input int          width);
      logic [15:0] base;
      logic [15:0] mask;
      base = load ? loadval : cur;
      mask = (width >= 16) ? 16'hffff : 16'h00ff;
      return (base + {15'h0000, hit}) & mask;
   endfunction : step_counter

   // Byte-lane merge of a write into an existing word.
   function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_lanes

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] crs_sync;
   logic [1:0] col_sync;
   logic [1:0] rx_dv_sync;
   logic [1:0] rx_er_sync;

   // PHY pins are asynchronous to aclk; only the second stage is read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crs_sync   <= 2'b00;
         col_sync   <= 2'b00;
         rx_dv_sync <= 2'b00;
         rx_er_sync <= 2'b00;
      end else begin
         crs_sync   <= {crs_sync[0], phy_crs};
         col_sync   <= {col_sync[0], collision_input};
         rx_dv_sync <= {rx_dv_sync[0], phy_rx_dv};
         rx_er_sync <= {rx_er_sync[0], phy_rx_er};
      end
   end

   wire crs_s   = crs_sync[1];
   wire col_s   = col_sync[1];
   wire rx_dv_s = rx_dv_sync[1];
   wire rx_er_s = rx_er_sync[1];

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   logic [31:0] net_config;
   wire         speed_fast  = net_config[CFG_SPEED_BIT];
   wire         half_duplex = !net_config[CFG_FULL_DUPLEX_BIT];
   wire         big_frames  = net_config[CFG_BIG_FRAMES_BIT];
   wire         len_check   = net_config[CFG_LEN_CHECK_BIT];
   wire  [13:0] max_len     = big_frames ? MAX_FRAME_BIG_BYTES : MAX_FRAME_BYTES;

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   logic                  aw_held;
   logic [ADDR_W-1:0]     aw_addr;
   logic                  w_held;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;

   // Address and data are caught in either order; the write fires once both are in.
   wire                   aw_take   = s_axi_awvalid && s_axi_awready;
   wire                   w_take    = s_axi_wvalid && s_axi_wready;
   wire                   wr_fire   = aw_held && w_held && !s_axi_bvalid;
   wire  [ADDR_W-1:0]     wr_off    = aw_addr - COUNTER_BASE;
   wire  [3:0]            wr_idx    = wr_off[5:2];
   wire                   wr_cfg    = wr_fire && (aw_addr[ADDR_W-1:2] == CONFIG_OFFSET[ADDR_W-1:2]);
   wire                   wr_cnt_ok = (aw_addr >= COUNTER_BASE) && (wr_off < ADDR_W'(4 * NUM_COUNTERS));
   wire                   wr_hit    = (aw_addr[ADDR_W-1:2] == CONFIG_OFFSET[ADDR_W-1:2]) || wr_cnt_ok;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   // Hold the write channels until the response has been handed over.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         w_held       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit side event detection
   // ---------------------------------------------------------------
   logic       tx_en_d;
   logic       carrier_seen;
   logic       carrier_dropped;
   logic       last_underrun;
   logic       sqe_armed;
   logic       sqe_col_seen;
   logic [6:0] sqe_bits;
   logic [3:0] bit_div;

   // A one-cycle pulse per bit time; 10 Mb/s needs ten clocks a bit.
   wire  [3:0] bit_cycles = speed_fast ? 4'(BIT_CYC_FAST) : 4'(BIT_CYC_SLOW);
   wire        bit_tick   = (bit_div == bit_cycles - 4'h1);
   wire        tx_end     = tx_en_d && !tx_en;
   wire        sqe_expire = sqe_armed && bit_tick && (sqe_bits == SQE_WINDOW_BITS - 7'd1);

   // Frame-level transmit decisions; an underrun frame takes no other counter.
   wire        tx_clean   = tx_frame_done && !tx_underrun;
   wire        ev_excess_collisions   = tx_clean && (tx_collision_total >= COLLISION_LIMIT);
   wire        ev_tx_underruns    = tx_frame_done && tx_underrun;
   wire        carrier_bad = !(carrier_seen || crs_s) || carrier_dropped;
   wire        ev_cse     = tx_clean && half_duplex && (tx_collision_total == 5'd0)
                            && carrier_bad;
   wire        ev_sqe     = sqe_expire && !sqe_col_seen && !col_s;

   // Carrier watch during transmit; it feeds only the carrier counter.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_en_d         <= 1'b0;
         carrier_seen    <= 1'b0;
         carrier_dropped <= 1'b0;
      end else begin
         tx_en_d <= tx_en;
         if (tx_en && !tx_en_d) begin
            carrier_seen    <= crs_s;
            carrier_dropped <= 1'b0;
         end else if (tx_en) begin
            carrier_seen    <= carrier_seen || crs_s;
            carrier_dropped <= carrier_dropped || (carrier_seen && !crs_s);
         end
      end
   end

   // Collision window after transmit end, half duplex only, skipped after an underrun.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_underrun <= 1'b0;
         sqe_armed     <= 1'b0;
         sqe_col_seen  <= 1'b0;
         sqe_bits      <= 7'd0;
         bit_div       <= 4'h0;
      end else begin
         bit_div <= (bit_tick || tx_end) ? 4'h0 : bit_div + 4'h1;
         if (tx_frame_done) begin
            last_underrun <= tx_underrun;
         end
         if (tx_end) begin
            sqe_armed    <= half_duplex && !(tx_frame_done ? tx_underrun : last_underrun);
            sqe_col_seen <= 1'b0;
            sqe_bits     <= 7'd0;
         end else if (sqe_armed) begin
            sqe_col_seen <= sqe_col_seen || col_s;
            if (sqe_expire || tx_en) begin
               sqe_armed <= 1'b0;
            end else if (bit_tick) begin
               sqe_bits <= sqe_bits + 7'd1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Receive side event detection
   // ---------------------------------------------------------------
   logic       symbol_seen;

   wire        sym_now    = symbol_seen || (rx_dv_s && rx_er_s);
   wire        rx_any_err = rx_crc_error || sym_now;
   wire        rx_over    = rx_frame_length > max_len;
   wire        rx_under   = rx_frame_length < MIN_FRAME_BYTES;
   wire        rx_in_rng  = !rx_over && !rx_under;
   wire [13:0] rx_payload = (rx_frame_length > HDR_FCS_BYTES) ? rx_frame_length - HDR_FCS_BYTES : 14'd0;

   wire        ev_rre     = rx_frame_done && rx_address_match && rx_no_buffer;
   wire        ev_rx_overruns    = rx_frame_done && rx_address_match && rx_dma_overrun;
   wire        ev_rse     = rx_frame_done && sym_now;
   wire        ev_exl     = rx_frame_done && rx_over && !rx_any_err;
   wire        ev_rjb     = rx_frame_done && rx_over && rx_any_err;
   wire        ev_usf     = rx_frame_done && rx_under && !rx_any_err;
   wire        ev_length_field_mismatches    = rx_frame_done && len_check
                            && (rx_length_field < TYPE_ID_MIN) && !rx_over
                            && ({2'b00, rx_payload} < rx_length_field);

   // Receive error is sticky over the frame; the frame end (rx_frame_done) clears it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         symbol_seen <= 1'b0;
      end else if (rx_frame_done) begin
         symbol_seen <= 1'b0;
      end else if (rx_dv_s && rx_er_s) begin
         symbol_seen <= 1'b1;
      end
   end

   // Symbol errors in range are handed to the FCS and alignment counters elsewhere.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_symbol_fcs_event   <= 1'b0;
         rx_symbol_align_event <= 1'b0;
      end else begin
         rx_symbol_fcs_event   <= rx_frame_done && sym_now && rx_in_rng && !rx_odd_bits;
         rx_symbol_align_event <= rx_frame_done && sym_now && rx_in_rng && rx_odd_bits;
      end
   end

   // ---------------------------------------------------------------
   // Counter bank
   // ---------------------------------------------------------------
   logic [15:0] counters [NUM_COUNTERS];
   logic [15:0] next_counters [NUM_COUNTERS];
   logic [NUM_COUNTERS-1:0] hits;
   logic [NUM_COUNTERS-1:0] loads;
   logic [31:0] wr_word;

   assign hits[CNT_EXCESS_COLLISIONS] = ev_excess_collisions;
   assign hits[CNT_TX_UNDERRUNS]      = ev_tx_underruns;
   assign hits[CNT_CARRIER_SENSE]     = ev_cse;
   assign hits[CNT_RX_RESOURCE]       = ev_rre;
   assign hits[CNT_RX_OVERRUNS]       = ev_rx_overruns;
   assign hits[CNT_RX_SYMBOL]         = ev_rse;
   assign hits[CNT_EXCESS_LENGTH]     = ev_exl;
   assign hits[CNT_RX_JABBERS]        = ev_rjb;
   assign hits[CNT_UNDERSIZE]         = ev_usf;
   assign hits[CNT_SQE_TEST]          = ev_sqe;
   assign hits[CNT_LENGTH_MISMATCH]   = ev_length_field_mismatches;

   // Byte enables merge into the current value so a partial write keeps other lanes.
   assign wr_word = merge_lanes({16'h0000, counters[wr_idx]}, w_data, w_strb);

   // Software load plus event, masked to each counter's width.
   always_comb begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         loads[i]         = wr_fire && wr_cnt_ok && (wr_idx == 4'(i));
         next_counters[i] = step_counter(counters[i], loads[i], wr_word[15:0], hits[i],
                                         counter_width(i));
      end
   end

   // Counters and configuration register update.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            counters[i] <= COUNTER_RESET;
         end
         net_config <= CONFIG_RESET;
      end else begin
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            counters[i] <= next_counters[i];
         end
         if (wr_cfg) begin
            net_config <= merge_lanes(net_config, w_data, w_strb) & CONFIG_MASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   wire  [ADDR_W-1:0] rd_off    = s_axi_araddr - COUNTER_BASE;
   wire  [3:0]        rd_idx    = rd_off[5:2];
   wire               rd_cfg    = s_axi_araddr[ADDR_W-1:2] == CONFIG_OFFSET[ADDR_W-1:2];
   wire               rd_cnt_ok = (s_axi_araddr >= COUNTER_BASE) && (rd_off < ADDR_W'(4 * NUM_COUNTERS));
   wire  [31:0]       rd_word   = rd_cfg    ? net_config :
                                  rd_cnt_ok ? {16'h0000, counters[rd_idx]} : 32'h0000_0000;

   assign s_axi_arready = !s_axi_rvalid;

   // One read at a time; data is registered on the accepting edge.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= (rd_cfg || rd_cnt_ok) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : eestat_counters

/* File: verification/eestat_checker.sv */
// Concurrent checks on the counter bank's bus and event ports.
`timescale 1ns/1ns
module eestat_checker (
   input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_frame_done,
   input wire logic        rx_odd_bits, rx_symbol_fcs_event, rx_symbol_align_event,
   input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
   input wire logic [13:0] rx_frame_length
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Legal-length frame end; the symbol events must trail one of these by one cycle.
   wire sym_ok = rx_frame_done && rx_frame_length >= 14'd64 && rx_frame_length <= 14'd1536;
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   wr_resp_a: assert property (wr_take_s |=> ##1 s_axi_bvalid)
      else $error("write answer missing");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
      else $error("read answer dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   fcs_ev_a: assert property (rx_symbol_fcs_event |-> $past(sym_ok) && !$past(rx_odd_bits))
      else $error("fcs event without cause");
   align_ev_a: assert property (rx_symbol_align_event |-> $past(sym_ok) && $past(rx_odd_bits))
      else $error("align event without cause");
endmodule : eestat_checker
bind eestat_counters eestat_checker i_eestat_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .rx_frame_done, .rx_odd_bits, .rx_symbol_fcs_event, .rx_symbol_align_event, .s_axi_bresp,
   .s_axi_rresp, .rx_frame_length);

/* File: verification/eestat_phy_model.sv */
// Behavioural PHY on the media side of the counter bank.
`timescale 1ns/1ns
module eestat_phy_model (
   input  wire logic aclk, tx_en, crs_mode, sqe_mode, rx_go, rx_err,
   output logic      phy_crs, collision_input, phy_rx_dv, phy_rx_er
);
   logic       tx_en_d;
   logic [7:0] gap;
   initial {tx_en_d, gap, phy_crs, collision_input, phy_rx_dv, phy_rx_er} = '0;
   // Carrier trails transmit by a cycle; the heartbeat lands well inside the 96-bit gap when asked for.
   always @(posedge aclk) begin
      tx_en_d         <= tx_en;
      gap             <= (tx_en_d && !tx_en) ? 8'h01 : (gap != 8'h00) ? gap + 8'h01 : 8'h00;
      phy_crs         <= crs_mode && tx_en;
      collision_input <= sqe_mode && gap > 8'd20 && gap < 8'd30;
      phy_rx_dv       <= rx_go;
      phy_rx_er       <= rx_go && rx_err;
   end
endmodule : eestat_phy_model

/* File: verification/eestat_counters_tb.sv */
// Self-checking bench for the error statistics counter bank.
`timescale 1ns/1ns
module eestat_counters_tb;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, tx_en = 0, tx_frame_done = 0, tx_underrun = 0, rx_frame_done = 0, rx_crc_error = 0;
   logic rx_odd_bits = 0, rx_address_match = 0, rx_no_buffer = 0, rx_dma_overrun = 0;
   logic crs_mode = 0, sqe_mode = 0, rx_go = 0, rx_err = 0, fd, big, lc, sp;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [4:0] tx_collision_total = 0;
   logic [13:0] rx_frame_length = 0;
   logic [15:0] rx_length_field = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phy_crs, collision_input;
   logic phy_rx_dv, phy_rx_er, rx_symbol_fcs_event, rx_symbol_align_event;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] ex [11];
   logic [13:0] lens [8] = '{14'd20, 14'd63, 14'd64, 14'd100, 14'd1518, 14'd1519, 14'd1536, 14'd1537};
   int err_count = 0, n_tests = 0;
   integer seed = 32'hf24f2c48;
   eestat_counters i_eestat_counters (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .tx_en, .tx_frame_done, .tx_collision_total, .tx_underrun, .phy_crs,
      .collision_input, .phy_rx_dv, .phy_rx_er, .rx_frame_done, .rx_frame_length, .rx_length_field, .rx_crc_error,
      .rx_odd_bits, .rx_address_match, .rx_no_buffer, .rx_dma_overrun, .rx_symbol_fcs_event, .rx_symbol_align_event);
   eestat_phy_model i_eestat_phy_model (.aclk, .tx_en, .crs_mode, .sqe_mode, .rx_go, .rx_err, .phy_crs,
      .collision_input, .phy_rx_dv, .phy_rx_er);
   always #5 aclk = ~aclk;
   // Expected counts wrap at each counter's own width.
   function automatic void inc(input int i);
      ex[i] = (ex[i] + 16'h1) & ((i == 3) ? 16'hffff : 16'h00ff);
   endfunction : inc
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict();
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   // Readies are sampled at the falling edge, where they are settled, and acted on at the next rising edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, tb;
      @(posedge aclk); {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'b11};
      do begin
         @(negedge aclk); ta = s_axi_awvalid && s_axi_awready; tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready; rs = s_axi_bresp;
         @(posedge aclk); if (ta) s_axi_awvalid <= 0; if (tw) s_axi_wvalid <= 0;
         if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
      end while (!tb);
      s_axi_bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge aclk); {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      do begin
         @(negedge aclk); ta = s_axi_arvalid && s_axi_arready; tr = s_axi_rvalid && s_axi_rready;
         {d, r} = {s_axi_rdata, s_axi_rresp};
         @(posedge aclk); if (ta) s_axi_arvalid <= 0; if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
      end while (!tr);
      s_axi_rready <= 0;
   endtask : rd
   task automatic rd_all();
      for (int i = 0; i < 11; i++) begin
         rd(8'h08 + 8'(4 * i)); chk("counter", {16'h0, ex[i]}, d);
      end
   endtask : rd_all
   task automatic tx(input logic [4:0] c, input logic u, cr, sq);
      @(posedge aclk); {crs_mode, sqe_mode, tx_en} <= {cr, sq, 1'b1};
      repeat (8) @(posedge aclk); {tx_frame_done, tx_collision_total, tx_underrun} <= {1'b1, c, u};
      @(posedge aclk); {tx_frame_done, tx_en} <= 2'b00;
      repeat (sp ? 110 : 980) @(posedge aclk);
      if (u) inc(1);
      else begin
         if (c >= 5'd16) inc(0);
         if (!fd && c == 5'd0 && !cr) inc(2);
         if (!fd && !sq) inc(9);
      end
   endtask : tx
   task automatic rx(input logic [13:0] ln, input logic [15:0] fl, input logic [5:0] q);
      logic ov, er, ok;
      @(posedge aclk); {rx_err, rx_go} <= {q[3], 1'b1};
      repeat (4) @(posedge aclk); rx_go <= 0;
      repeat (4) @(posedge aclk); {rx_frame_done, rx_frame_length, rx_length_field} <= {1'b1, ln, fl};
      {rx_crc_error, rx_odd_bits, rx_address_match, rx_no_buffer, rx_dma_overrun} <= {q[5:4], q[2:0]};
      @(posedge aclk); rx_frame_done <= 0;
      @(negedge aclk); ov = ln > (big ? 14'd1536 : 14'd1518); er = q[5] | q[3]; ok = q[3] && ln >= 14'd64 && !ov;
      chk("fcs event", {31'h0, ok && !q[4]}, {31'h0, rx_symbol_fcs_event});
      chk("align event", {31'h0, ok && q[4]}, {31'h0, rx_symbol_align_event});
      if (q[2] && q[1]) inc(3);
      if (q[2] && q[0]) inc(4);
      if (q[3]) inc(5);
      if (ov) inc(er ? 7 : 6);
      if (ln < 14'd64 && !er) inc(8);
      if (lc && fl < 16'h0600 && !ov && ((ln > 14'd18) ? 16'(ln - 14'd18) : 16'h0) < fl) inc(10);
   endtask : rx
   // Main sequence: reset, map corners, then random traffic with periodic readback and reloads.
   initial begin
      for (int i = 0; i < 11; i++) ex[i] = 16'h0;
      repeat (20) @(posedge aclk); aresetn <= 1;
      rd_all();
      rd(8'h34); chk("unmapped read", 32'h2, {30'h0, r});
      wr(8'h48, 32'h5a5a_a5a5, r); chk("unmapped write", 32'h2, {30'h0, r});
      for (int k = 0; k < 40; k++) begin
         {sp, fd, big, lc} = 4'($random(seed));
         wr(8'h00, {15'h0, lc, 7'h0, big, 6'h0, fd, sp}, r);
         tx(($random(seed) & 1) ? 5'd0 : 5'($random(seed)), ($random(seed) & 3) == 0, 1'($random(seed)),
            1'($random(seed)));
         rx(lens[3'($random(seed))], 16'($random(seed)) & 16'h0fff, 6'($random(seed)));
         if (k % 10 == 9) begin
            rd(8'h00); chk("config", {15'h0, lc, 7'h0, big, 6'h0, fd, sp}, d);
            rd_all(); d = $random(seed); ex[k / 10] = d[15:0] & ((k / 10 == 3) ? 16'hffff : 16'h00ff);
            wr(8'h08 + 8'(4 * (k / 10)), d, r); chk("write resp", 32'h0, {30'h0, r});
         end
      end
      rd_all();
      print_verdict();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #600000;
      err_count++;
      print_verdict();
   end
endmodule : eestat_counters_tb
